// ==== design/qdc_pkg.sv ====
// Shared constants and carrier types of the quadrature decoder control
package qdc_pkg;

    // ------------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------------
    localparam logic [5:0] QDC_IDX_POS_COUNTER = 6'h00;
    localparam logic [5:0] QDC_IDX_POS_INIT    = 6'h02;
    localparam logic [5:0] QDC_IDX_POS_MAX     = 6'h04;
    localparam logic [5:0] QDC_IDX_POS_CMP     = 6'h06;
    localparam logic [5:0] QDC_IDX_INDEX_LATCH = 6'h08;
    localparam logic [5:0] QDC_IDX_STROBE_LAT  = 6'h0a;
    localparam logic [5:0] QDC_IDX_PERIOD_LAT  = 6'h0c;
    localparam logic [5:0] QDC_IDX_UNIT_TIMER  = 6'h0e;
    localparam logic [5:0] QDC_IDX_UNIT_PERIOD = 6'h10;
    localparam logic [5:0] QDC_IDX_STALL_TIMER = 6'h12;
    localparam logic [5:0] QDC_IDX_STALL_PER   = 6'h13;
    localparam logic [5:0] QDC_IDX_DEC_CTRL    = 6'h14;
    localparam logic [5:0] QDC_IDX_POS_CTRL    = 6'h15;
    localparam logic [5:0] QDC_IDX_STATUS      = 6'h1c;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [31:0] QDC_RST_WORD = 32'h0000_0000;
    localparam logic [15:0] QDC_RST_HALF = 16'h0000;

    // ------------------------------------------------------------------
    // Decoder control fields
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [1:0] counter_source;
        logic       sync_out_enable;
        logic       sync_pin_choice;
        logic       ext_clock_rate;
        logic       input_swap;
        logic       index_gating;
        logic       phase_a_invert;
        logic       phase_b_invert;
        logic       index_invert;
        logic       strobe_invert;
        logic [3:0] reserved;
        logic       dir_at_index_fix;
    } qdc_dec_ctrl_s;

    // ------------------------------------------------------------------
    // Position control fields
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [1:0] emu_mode;
        logic [1:0] counter_reset_mode;
        logic [1:0] strobe_init_mode;
        logic [1:0] index_init_mode;
        logic       soft_init;
        logic       strobe_latch_mode;
        logic [1:0] index_latch_mode;
        logic       counter_enable;
        logic       capture_latch_mode;
        logic       unit_timer_on;
        logic       stall_timer_on;
    } qdc_pos_ctrl_s;

    localparam logic [15:0] QDC_DEC_RESERVED_MASK = 16'hffe1;

    // Counter source codes
    localparam logic [1:0] QDC_SRC_QUAD = 2'h0;
    localparam logic [1:0] QDC_SRC_DIR  = 2'h1;
    localparam logic [1:0] QDC_SRC_UP   = 2'h2;
    localparam logic [1:0] QDC_SRC_DOWN = 2'h3;

    // Position reset modes
    localparam logic [1:0] QDC_PRST_INDEX = 2'h0;
    localparam logic [1:0] QDC_PRST_MAX   = 2'h1;
    localparam logic [1:0] QDC_PRST_FIRST = 2'h2;
    localparam logic [1:0] QDC_PRST_UNIT  = 2'h3;

    // Init and latch codes
    localparam logic [1:0] QDC_INIT_RISE = 2'h2;
    localparam logic [1:0] QDC_INIT_DIR  = 2'h3;
    localparam logic [1:0] QDC_ILAT_RISE = 2'h1;
    localparam logic [1:0] QDC_ILAT_FALL = 2'h2;
    localparam logic [1:0] QDC_ILAT_MARK = 2'h3;

    // Emulation suspend codes
    localparam logic [1:0] QDC_EMU_STOP = 2'h0;
    localparam logic [1:0] QDC_EMU_SOFT = 2'h1;

    // ------------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic phase_a_input;
        logic phase_b_input;
        logic index_input;
        logic strobe_input;
    } qdc_enc_pins_s;

    typedef struct packed {
        logic index_out;
        logic index_oe_n;
        logic strobe_out;
        logic strobe_oe_n;
    } qdc_sync_pins_s;

endpackage : qdc_pkg

// ==== design/qdc_quadrature_decoder_control.sv ====
// Quadrature decoder control core with APB register slave
// What this block does
// [R1] Unit timer compared with 32-bit period; match makes a unit event.
// [R2] Software writes the unit period only as whole 32-bit words.
// [R3] 16-bit stall timer equal to stall period raises a timeout.
// [R4] Every count clock edge clears the stall timer to zero.
// [R5] Source: quadrature, external clock/dir, external up, external down.
// [R6] Sync enable gates sync output; pin choice picks index or strobe.
// [R7] External clock counts both edges at 0, rising only at 1.
// [R8] Swap bit exchanges the two phase inputs before decoding.
// [R9] Index gating bit qualifies index with strobe.
// [R10] Four invert bits negate phase A, phase B, index and strobe.
// [R11] Fix bit blocks A-rising count when direction changes at index.
// [R12] Suspend: code 0 stops, code 1 runs to rollover, 2/3 run.
// [R13] Position reset on index, at maximum, first index, or unit event.
// [R14] Strobe init loads init value on rising or direction-based edge.
// [R15] Index init loads init value on index rising or falling edge.
// [R16] Soft init bit loads init value while set; software clears it.
// [R17] Strobe latch on rising edge or direction-based edge.
// [R18] Index latch on rising, falling, or marker with direction flag.
// [R19] Counter enable low holds flags and read-only latches in reset.
// [R20] Capture latch on position read, or position latch at unit event.
// [R21] Unit timer and stall timer each run only when enabled.
// [R22] Unit event copies position counter to periodic position latch.
// [R23] Position counter steps up or down on each count clock.
// [R24] Unit timer restarts from zero after period match.
// [R25] Stall timer restarts from zero after period match.
//
// Chosen here: register access over APB.
module qdc_quadrature_decoder_control
    import qdc_pkg::*;
(
    input  wire logic                    pclk,
    input  wire logic                    presetn,
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [7:0]              paddr,
    input  wire logic [31:0]             pwdata,
    output logic      [31:0]             prdata,
    output logic                         pready,
    output logic                         pslverr,
    input  wire qdc_pkg::qdc_enc_pins_s  enc_pins,
    input  wire logic                    emu_suspend,
    output qdc_pkg::qdc_sync_pins_s      sync_pins,
    output logic                         unit_event,
    output logic                         stall_timeout,
    output logic                         capture_latch_req
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [31:0]   pos;
        logic [31:0]   pos_init;
        logic [31:0]   pos_max;
        logic [31:0]   pos_cmp;
        logic [31:0]   idx_lat;
        logic [31:0]   stb_lat;
        logic [31:0]   per_lat;
        logic [31:0]   unit_tmr;
        logic [31:0]   unit_per;
        logic [15:0]   stall_tmr;
        logic [15:0]   stall_per;
        qdc_dec_ctrl_s dec;
        qdc_pos_ctrl_s pctl;
        logic [3:0]    pins_q;
        logic          dir;
        logic          dir_flag;
        logic          first_idx_done;
        logic          frz_pos;
        logic          frz_unit;
        logic          frz_stall;
        logic          sync;
        logic          unit_evt;
        logic          stall_evt;
        logic          cap_req;
        logic [31:0]   rdata;
    } qdc_state_s;

    qdc_state_s st_ff;
    qdc_state_s nxt_st;

    function automatic logic is_reg(input logic [7:0] a,
                                    input logic [5:0] idx);
        is_reg = (a == {idx, 2'b00});
    endfunction : is_reg

    function automatic logic edge_hit(input logic rise, input logic fall,
                                      input logic by_dir,
                                      input logic up);
        edge_hit = by_dir ? (up ? rise : fall) : rise;
    endfunction : edge_hit

    // ------------------------------------------------------------------
    // Input conditioning and decoding
    // ------------------------------------------------------------------
    logic [3:0]  pins_c;
    logic        a_c;
    logic        b_c;
    logic        a_p;
    logic        b_p;
    logic        idx_rise;
    logic        idx_fall;
    logic        stb_rise;
    logic        stb_fall;
    logic        a_rise;
    logic        a_fall;
    logic        cnt_clk;
    logic        cnt_dir;
    logic        quad_step;
    logic        mapped;
    logic        run_pos;
    logic        run_unit;
    logic        run_stall;
    logic        unit_hit;
    logic        stall_hit;
    logic        at_top;
    logic        at_bottom;
    logic        do_init;
    logic        do_reset;
    logic        roll;
    logic [15:0] wd16;
    logic [31:0] rd_word;

    always_comb
    begin
        pins_c[3] = enc_pins.phase_a_input ^ st_ff.dec.phase_a_invert; // [R10]
        pins_c[2] = enc_pins.phase_b_input ^ st_ff.dec.phase_b_invert; // [R10]
        pins_c[1] = enc_pins.index_input ^ st_ff.dec.index_invert;    // [R10]
        pins_c[0] = enc_pins.strobe_input ^ st_ff.dec.strobe_invert;  // [R10]
        if (st_ff.dec.index_gating)
        begin
            pins_c[1] = pins_c[1] & pins_c[0]; // [R9]
        end
        a_c = st_ff.dec.input_swap ? pins_c[2] : pins_c[3]; // [R8]
        b_c = st_ff.dec.input_swap ? pins_c[3] : pins_c[2]; // [R8]
        a_p = st_ff.pins_q[3];
        b_p = st_ff.pins_q[2];
        idx_rise = pins_c[1] & ~st_ff.pins_q[1];
        idx_fall = ~pins_c[1] & st_ff.pins_q[1];
        stb_rise = pins_c[0] & ~st_ff.pins_q[0];
        stb_fall = ~pins_c[0] & st_ff.pins_q[0];
        a_rise = a_c & ~a_p;
        a_fall = ~a_c & a_p;
        quad_step = (a_c ^ a_p) ^ (b_c ^ b_p);
        cnt_clk = a_rise | (a_fall & ~st_ff.dec.ext_clock_rate); // [R7]
        unique case (st_ff.dec.counter_source) // [R5]
            QDC_SRC_QUAD:
            begin
                cnt_clk = quad_step;
                cnt_dir = a_c ^ b_p;
            end
            QDC_SRC_DIR:  cnt_dir = b_c;
            QDC_SRC_UP:   cnt_dir = 1'b1;
            QDC_SRC_DOWN: cnt_dir = 1'b0;
        endcase
        if (st_ff.dec.dir_at_index_fix && a_rise && (idx_rise || idx_fall)
            && cnt_clk && (cnt_dir != st_ff.dir))
        begin
            cnt_clk = 1'b0; // [R11]
        end
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb
    begin
        nxt_st = st_ff;
        wd16 = pwdata[15:0];
        nxt_st.pins_q = {a_c, b_c, pins_c[1:0]};
        nxt_st.sync = 1'b0;
        nxt_st.unit_evt = 1'b0;
        nxt_st.stall_evt = 1'b0;
        nxt_st.cap_req = 1'b0;

        // Suspend handling
        run_pos = ~(emu_suspend & ((st_ff.pctl.emu_mode == QDC_EMU_STOP)
                  | st_ff.frz_pos)); // [R12]
        run_unit = ~(emu_suspend & ((st_ff.pctl.emu_mode == QDC_EMU_STOP)
                   | st_ff.frz_unit)); // [R12]
        run_stall = ~(emu_suspend & ((st_ff.pctl.emu_mode == QDC_EMU_STOP)
                    | st_ff.frz_stall)); // [R12]

        // Unit timer
        unit_hit = 1'b0;
        if (st_ff.pctl.unit_timer_on && run_unit) // [R21]
        begin
            if (st_ff.unit_tmr == st_ff.unit_per) // [R1]
            begin
                unit_hit = 1'b1;
                nxt_st.unit_tmr = QDC_RST_WORD; // [R24]
            end
            else
            begin
                nxt_st.unit_tmr = st_ff.unit_tmr + 32'h0000_0001;
            end
        end
        nxt_st.unit_evt = unit_hit;

        // Stall watchdog
        stall_hit = 1'b0;
        if (cnt_clk)
        begin
            nxt_st.stall_tmr = QDC_RST_HALF; // [R4]
        end
        else if (st_ff.pctl.stall_timer_on && run_stall) // [R21]
        begin
            if (st_ff.stall_tmr == st_ff.stall_per) // [R3]
            begin
                stall_hit = 1'b1;
                nxt_st.stall_tmr = QDC_RST_HALF; // [R25]
            end
            else
            begin
                nxt_st.stall_tmr = st_ff.stall_tmr + 16'h0001;
            end
        end
        nxt_st.stall_evt = stall_hit;

        // Position counter
        at_top = (st_ff.pos == st_ff.pos_max);
        at_bottom = (st_ff.pos == QDC_RST_WORD);
        roll = 1'b0;
        do_init = st_ff.pctl.soft_init // [R16]
            | ((st_ff.pctl.strobe_init_mode == QDC_INIT_RISE) & stb_rise)
            | ((st_ff.pctl.strobe_init_mode == QDC_INIT_DIR)
               & edge_hit(stb_rise, stb_fall, 1'b1, st_ff.dir)) // [R14]
            | ((st_ff.pctl.index_init_mode == QDC_INIT_RISE) & idx_rise)
            | ((st_ff.pctl.index_init_mode == QDC_INIT_DIR) & idx_fall); // [R15]
        unique case (st_ff.pctl.counter_reset_mode) // [R13]
            QDC_PRST_INDEX: do_reset = idx_rise;
            QDC_PRST_FIRST: do_reset = idx_rise & ~st_ff.first_idx_done;
            QDC_PRST_UNIT:  do_reset = unit_hit;
            QDC_PRST_MAX:   do_reset = 1'b0;
        endcase
        if (st_ff.pctl.counter_enable)
        begin
            if (do_init)
            begin
                nxt_st.pos = st_ff.pos_init;
            end
            else if (do_reset && run_pos)
            begin
                nxt_st.pos = cnt_dir ? QDC_RST_WORD : st_ff.pos_max; // [R13]
                if (idx_rise)
                begin
                    nxt_st.first_idx_done = 1'b1;
                end
            end
            else if (cnt_clk && run_pos)
            begin
                nxt_st.dir = cnt_dir;
                if (st_ff.pctl.counter_reset_mode == QDC_PRST_MAX) // [R13]
                begin
                    roll = cnt_dir ? at_top : at_bottom;
                    if (cnt_dir)
                        nxt_st.pos = at_top ? QDC_RST_WORD
                                            : st_ff.pos + 32'h0000_0001;
                    else
                        nxt_st.pos = at_bottom ? st_ff.pos_max
                                               : st_ff.pos - 32'h0000_0001;
                end
                else
                begin
                    roll = cnt_dir ? (&st_ff.pos) : at_bottom;
                    nxt_st.pos = cnt_dir ? st_ff.pos + 32'h0000_0001
                                         : st_ff.pos - 32'h0000_0001; // [R23]
                end
            end
            // Latches
            if (edge_hit(stb_rise, stb_fall, st_ff.pctl.strobe_latch_mode,
                         st_ff.dir)) // [R17]
            begin
                nxt_st.stb_lat = st_ff.pos;
            end
            unique case (st_ff.pctl.index_latch_mode) // [R18]
                QDC_ILAT_RISE: if (idx_rise) nxt_st.idx_lat = st_ff.pos;
                QDC_ILAT_FALL: if (idx_fall) nxt_st.idx_lat = st_ff.pos;
                QDC_ILAT_MARK:
                begin
                    if (idx_rise)
                    begin
                        nxt_st.idx_lat = st_ff.pos;
                        nxt_st.dir_flag = st_ff.dir;
                    end
                end
                default: ;
            endcase
            if (unit_hit)
            begin
                nxt_st.per_lat = st_ff.pos; // [R22]
                if (st_ff.pctl.capture_latch_mode)
                begin
                    nxt_st.idx_lat = st_ff.pos; // [R20]
                    nxt_st.cap_req = 1'b1;      // [R20]
                end
            end
            if (st_ff.dec.sync_out_enable && (nxt_st.pos == st_ff.pos_cmp)
                && (nxt_st.pos != st_ff.pos))
            begin
                nxt_st.sync = 1'b1; // [R6]
            end
        end
        else
        begin
            nxt_st.idx_lat = QDC_RST_WORD;   // [R19]
            nxt_st.stb_lat = QDC_RST_WORD;   // [R19]
            nxt_st.per_lat = QDC_RST_WORD;   // [R19]
            nxt_st.dir = 1'b0;               // [R19]
            nxt_st.dir_flag = 1'b0;          // [R19]
            nxt_st.first_idx_done = 1'b0;    // [R19]
        end

        // Soft-suspend freeze points
        nxt_st.frz_pos = emu_suspend & (st_ff.frz_pos
            | ((st_ff.pctl.emu_mode == QDC_EMU_SOFT) & roll)); // [R12]
        nxt_st.frz_unit = emu_suspend & (st_ff.frz_unit
            | ((st_ff.pctl.emu_mode == QDC_EMU_SOFT) & unit_hit)); // [R12]
        nxt_st.frz_stall = emu_suspend & (st_ff.frz_stall
            | ((st_ff.pctl.emu_mode == QDC_EMU_SOFT) & stall_hit)); // [R12]

        // ------------------------------------------------------------------
        // APB access
        // ------------------------------------------------------------------
        mapped = (paddr[1:0] == 2'b00);
        rd_word = QDC_RST_WORD;
        unique case (paddr[7:2])
            QDC_IDX_POS_COUNTER: rd_word = st_ff.pos;
            QDC_IDX_POS_INIT:    rd_word = st_ff.pos_init;
            QDC_IDX_POS_MAX:     rd_word = st_ff.pos_max;
            QDC_IDX_POS_CMP:     rd_word = st_ff.pos_cmp;
            QDC_IDX_INDEX_LATCH: rd_word = st_ff.idx_lat;
            QDC_IDX_STROBE_LAT:  rd_word = st_ff.stb_lat;
            QDC_IDX_PERIOD_LAT:  rd_word = st_ff.per_lat;
            QDC_IDX_UNIT_TIMER:  rd_word = st_ff.unit_tmr;
            QDC_IDX_UNIT_PERIOD: rd_word = st_ff.unit_per;
            QDC_IDX_STALL_TIMER: rd_word = {16'h0000, st_ff.stall_tmr};
            QDC_IDX_STALL_PER:   rd_word = {16'h0000, st_ff.stall_per};
            QDC_IDX_DEC_CTRL:    rd_word = {16'h0000, st_ff.dec};
            QDC_IDX_POS_CTRL:    rd_word = {16'h0000, st_ff.pctl};
            QDC_IDX_STATUS:      rd_word = {28'h0000000, st_ff.first_idx_done,
                                st_ff.stall_evt, st_ff.dir, st_ff.dir_flag};
            default:             mapped = 1'b0;
        endcase
        if (psel && !penable && !pwrite)
        begin
            nxt_st.rdata = mapped ? rd_word : QDC_RST_WORD;
        end
        if (psel && penable && !pwrite
            && is_reg(paddr, QDC_IDX_POS_COUNTER)
            && !st_ff.pctl.capture_latch_mode)
        begin
            nxt_st.cap_req = 1'b1; // [R20]
        end
        if (psel && penable && pwrite)
        begin
            if (is_reg(paddr, QDC_IDX_POS_COUNTER)) nxt_st.pos = pwdata;
            if (is_reg(paddr, QDC_IDX_POS_INIT)) nxt_st.pos_init = pwdata;
            if (is_reg(paddr, QDC_IDX_POS_MAX)) nxt_st.pos_max = pwdata;
            if (is_reg(paddr, QDC_IDX_POS_CMP)) nxt_st.pos_cmp = pwdata;
            if (is_reg(paddr, QDC_IDX_UNIT_TIMER)) nxt_st.unit_tmr = pwdata;
            if (is_reg(paddr, QDC_IDX_UNIT_PERIOD))
                nxt_st.unit_per = pwdata; // [R2]
            if (is_reg(paddr, QDC_IDX_STALL_TIMER)) nxt_st.stall_tmr = wd16;
            if (is_reg(paddr, QDC_IDX_STALL_PER)) nxt_st.stall_per = wd16;
            if (is_reg(paddr, QDC_IDX_DEC_CTRL))
                nxt_st.dec = qdc_dec_ctrl_s'(wd16 & QDC_DEC_RESERVED_MASK);
            if (is_reg(paddr, QDC_IDX_POS_CTRL))
                nxt_st.pctl = qdc_pos_ctrl_s'(wd16); // [R16]
        end
    end

    // ------------------------------------------------------------------
    // Registers and outputs
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            st_ff <= '0;
        else
            st_ff <= nxt_st;
    end

    assign prdata = st_ff.rdata;
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~mapped;
    assign unit_event = st_ff.unit_evt;
    assign stall_timeout = st_ff.stall_evt;
    assign capture_latch_req = st_ff.cap_req;
    assign sync_pins.index_out = st_ff.sync & ~sync_pins.index_oe_n; // [R6]
    assign sync_pins.strobe_out = st_ff.sync & ~sync_pins.strobe_oe_n; // [R6]
    assign sync_pins.index_oe_n =
        ~(st_ff.dec.sync_out_enable & ~st_ff.dec.sync_pin_choice); // [R6]
    assign sync_pins.strobe_oe_n =
        ~(st_ff.dec.sync_out_enable & st_ff.dec.sync_pin_choice); // [R6]

endmodule : qdc_quadrature_decoder_control

// ==== sim/qdc_properties.sv ====
// Port assertions of the quadrature decoder control
module qdc_quadrature_decoder_control_chk
    import qdc_pkg::*;
(
    input wire logic                    pclk,
    input wire logic                    presetn,
    input wire logic                    psel,
    input wire logic                    penable,
    input wire logic                    pwrite,
    input wire logic [7:0]              paddr,
    input wire logic [31:0]             prdata,
    input wire logic                    pready,
    input wire logic                    pslverr,
    input wire qdc_pkg::qdc_sync_pins_s sync_pins
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    chk_ready_high: assert property (pready) else $error("pready low");
    chk_err_access: assert property (pslverr |-> psel && penable)
        else $error("pslverr outside access");
    chk_err_unmapped: assert property (psel && penable && paddr == 8'h44
        |-> pslverr) else $error("unmapped without pslverr");
    chk_err_mapped: assert property (psel && penable && paddr == 8'h40
        |-> !pslverr) else $error("mapped with pslverr");
    chk_err_rdata: assert property (psel && penable && !pwrite && pslverr
        |-> prdata == 32'h0) else $error("unmapped read not zero");
    chk_resv_zero: assert property (psel && penable && !pwrite
        && paddr == 8'h50 |-> prdata[4:1] == 4'h0)
        else $error("reserved bits set");
    chk_pin_single: assert property (
        sync_pins.index_oe_n || sync_pins.strobe_oe_n)
        else $error("both sync pins driven");
    chk_index_gate: assert property (
        sync_pins.index_out |-> !sync_pins.index_oe_n)
        else $error("index pulse undriven");
    chk_strobe_gate: assert property (
        sync_pins.strobe_out |-> !sync_pins.strobe_oe_n)
        else $error("strobe pulse undriven");
endmodule : qdc_quadrature_decoder_control_chk
bind qdc_quadrature_decoder_control qdc_quadrature_decoder_control_chk
    i_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sync_pins(sync_pins));

// ==== sim/qdc_encoder_model.sv ====
// Encoder model: gray-coded phases, index and strobe idle low
module qdc_encoder_model
    import qdc_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              step,
    input  wire logic              dir_up,
    output qdc_pkg::qdc_enc_pins_s pins
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] ph_ff = 2'h0;
    always_ff @(posedge clk)
        if (step)
            ph_ff <= ph_ff + (dir_up ? 2'h1 : 2'h3);
    assign pins = {ph_ff[1] ^ ph_ff[0], ph_ff[1], 2'h0};
endmodule : qdc_encoder_model

// ==== sim/qdc_quadrature_decoder_control_tb.sv ====
// Self-checking bench of the quadrature decoder control
module qdc_quadrature_decoder_control_tb;
    import qdc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk, presetn, psel, penable, pwrite, step, dir_up, er, sus, cap;
    logic pready, pslverr, unit_event, stall_timeout;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q;
    qdc_enc_pins_s enc;
    qdc_sync_pins_s sync_pins;
    int err_total, n_checks, cyc, n_to, n_sy, k;
    qdc_quadrature_decoder_control i_qdc_quadrature_decoder_control (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .enc_pins(enc),
        .emu_suspend(sus), .sync_pins(sync_pins), .unit_event(unit_event),
        .stall_timeout(stall_timeout), .capture_latch_req(cap));
    qdc_encoder_model i_qdc_encoder_model (.clk(pclk), .step(step),
        .dir_up(dir_up), .pins(enc));
    initial
    begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    always @(posedge pclk)
    begin
        cyc++;
        n_to += (stall_timeout === 1'b1);
        n_sy += (sync_pins.index_out === 1'b1);
        if (cyc == 5000)
        begin
            err_total++;
            give_verdict();
        end
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e)
        begin
            err_total++;
            $display("Error at %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    task automatic apb(input bit w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic gap(input bit w, input logic [31:0] e);
        int n;
        n = 0;
        do @(posedge pclk); while ((w ? stall_timeout : unit_event) !== 1'b1);
        do
        begin
            @(posedge pclk);
            n++;
        end while ((w ? stall_timeout : unit_event) !== 1'b1 && n < 99);
        chk(n, e);
    endtask : gap
    task automatic mv(input int n, input logic up);
        repeat (n)
        begin
            @(posedge pclk);
            step <= 1'b1;
            dir_up <= up;
            @(posedge pclk);
            step <= 1'b0;
            repeat (3) @(posedge pclk);
        end
    endtask : mv
    task automatic give_verdict();
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : give_verdict
    task automatic t_regs();
        logic [7:0] a[5] = '{8'h40, 8'h48, 8'h4c, 8'h50, 8'h54};
        foreach (a[i])
        begin
            apb(0, a[i], 0);
            chk(q, 0);
        end
        apb(1, 8'h40, 32'ha5a5_5a5a);
        apb(0, 8'h40, 0);
        chk(q, 32'ha5a5_5a5a);
        apb(1, 8'h50, 32'hffff_ffff);
        apb(0, 8'h50, 0);
        chk(q, 32'h0000_ffe1);
        apb(1, 8'h50, 0);
        apb(0, 8'h44, 0);
        chk({q[30:0], er}, 32'h1);
        $display("t_regs done");
    endtask : t_regs
    task automatic t_motion();
        apb(1, 8'h40, 32'h4);
        apb(1, 8'h4c, 32'hffff_0006);
        apb(0, 8'h4c, 0);
        chk(q, 32'h6);
        apb(1, 8'h54, 32'h000b);
        gap(0, 5);
        gap(1, 7);
        @(posedge pclk);
        k = n_to;
        mv(8, 1);
        chk(n_to - k, 0);
        apb(0, 8'h00, 0);
        chk(q, 32'h8);
        @(posedge pclk);
        chk(cap, 1'b1);
        mv(2, 0);
        apb(0, 8'h00, 0);
        chk(q, 32'h6);
        apb(1, 8'h50, 32'h0400);
        mv(2, 1);
        apb(0, 8'h00, 0);
        chk(q, 32'h4);
        apb(1, 8'h18, 32'h5);
        apb(1, 8'h50, 32'h2000);
        k = n_sy;
        mv(1, 1);
        chk(n_sy - k, 1);
        chk(sync_pins, 32'h1);
        apb(1, 8'h08, 32'h2a);
        apb(1, 8'h54, 32'h008b);
        apb(0, 8'h00, 0);
        chk(q, 32'h2a);
        apb(0, 8'h54, 0);
        chk(q, 32'h008b);
        sus <= 1'b1;
        apb(0, 8'h38, 0);
        k = q;
        apb(0, 8'h38, 0);
        chk(q, k);
        sus <= 1'b0;
        $display("t_motion done");
    endtask : t_motion
    initial
    begin
        {presetn, psel, penable, pwrite, step, dir_up, er, sus} = '0;
        paddr = '0;
        pwdata = '0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_motion();
        give_verdict();
    end
endmodule : qdc_quadrature_decoder_control_tb
